// File: bitr_pkg.sv
// Package: constants and types for the built-in test reporter
package bitr_pkg;
    localparam int ERR_W          = 10;
    localparam int BASIC_TESTS    = 5;
    localparam int SW_W           = 5;
    // Error bit positions
    localparam int BIT_PROG_MEM   = 0;
    localparam int BIT_WORK_MEM   = 1;
    localparam int BIT_NV_STORE   = 2;
    localparam int BIT_OPT_BUF    = 3;
    localparam int BIT_DIG_POT    = 4;
    localparam int BIT_LOOPBACK   = 5;
    localparam int BIT_VMAX       = 6;
    localparam int BIT_VMIN       = 7;
    localparam int BIT_QTR_V      = 8;
    localparam int BIT_QTR_RB     = 9;
    localparam int BIT_ANALOG_PRE = 5;   // First analogue-stage subtest
    // Beep counts per failure, for ready and for none
    localparam logic [2:0] BEEPS_MEM      = 3'h1;
    localparam logic [2:0] BEEPS_NV       = 3'h2;
    localparam logic [2:0] BEEPS_OPT      = 3'h3;
    localparam logic [2:0] BEEPS_POT      = 3'h6;
    localparam logic [2:0] BEEPS_LOOP     = 3'h5;
    localparam logic [2:0] BEEPS_READY    = 3'h3;
    localparam logic [2:0] BEEPS_NONE     = 3'h0;
    // Switch codes, section five down to one, 1 = open
    localparam logic [SW_W-1:0] SW_ALL_OPEN = 5'h1f;
    localparam logic [SW_W-1:0] SW_BAUD_9K6  = 5'h06;
    localparam logic [SW_W-1:0] SW_BAUD_19K2 = 5'h01;
    localparam logic [SW_W-1:0] SW_BAUD_38K4 = 5'h03;
    localparam logic [ERR_W-1:0] ERR_PASS    = 10'h000;
    localparam logic [ERR_W-1:0] ERR_NONE    = 10'h000;
    // Beep timing
    localparam int CLK_MHZ        = 200;
    localparam int BEEP_MS        = 100;
    localparam int BEEP_CYCLES    = BEEP_MS * 1000 * CLK_MHZ;
    localparam int PERIODIC_MS    = 1000;
    localparam int PERIODIC_CYCLES = PERIODIC_MS * 1000 * CLK_MHZ;
    typedef enum logic [1:0] {
        BITR_BAUD_9K6,
        BITR_BAUD_19K2,
        BITR_BAUD_38K4,
        BITR_BAUD_INVALID
    } bitr_baud_type;
    typedef enum logic [1:0] {
        BITR_TRIG_POWERUP,
        BITR_TRIG_PERIODIC,
        BITR_TRIG_CONFIDENCE,
        BITR_TRIG_FULL
    } bitr_trig_type;
endpackage

// File: bitr_beeper.sv
// Beep pattern generator: counted bursts or a steady equal-period toggle
`timescale 1ns/1ps
module bitr_beeper
    import bitr_pkg::*;
#(
    parameter int HALF_CYCLES = BEEP_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_start,
    input  wire logic [2:0] i_count,
    input  wire logic       i_toggle,
    output logic            o_beep,
    output logic            o_busy
);
    logic [31:0] tick_reg;
    logic [3:0]  phase_reg;
    logic        tick_end;
    assign tick_end = (tick_reg == 32'(HALF_CYCLES - 1));
    // Half-period timer runs while a pattern is active
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_reg <= 32'h0000_0000;
        end else if (i_start || tick_end || !(o_busy || i_toggle)) begin
            tick_reg <= 32'h0000_0000;
        end else begin
            tick_reg <= tick_reg + 32'h0000_0001;
        end
    end

    // Each beep is an on half and an off half; phases count down
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_reg <= 4'h0;
            o_beep    <= 1'b0;
            o_busy    <= 1'b0;
        end else if (i_start && i_count != BEEPS_NONE) begin
            phase_reg <= {i_count, 1'b0} - 4'h1;
            o_beep    <= 1'b1;
            o_busy    <= 1'b1;
        end else if (o_busy) begin
            if (tick_end) begin
                if (phase_reg == 4'h0) begin
                    o_busy <= 1'b0;
                    o_beep <= 1'b0;
                end else begin
                    phase_reg <= phase_reg - 4'h1;
                    o_beep    <= ~o_beep;
                end
            end
        end else if (i_toggle) begin
            if (tick_end) begin
                o_beep <= ~o_beep;  // Equal on and off periods
            end
        end else begin
            o_beep <= 1'b0;
        end
    end
endmodule

// File: bitr_reporter.sv
// Built-in test reporter: sequences subtests, accumulates codes, drives beeps
`timescale 1ns/1ps
module bitr_reporter
    import bitr_pkg::*;
#(
    parameter int BEEP_HALF    = BEEP_CYCLES,
    parameter int PERIOD_TICKS = PERIODIC_CYCLES
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_confidence_query,    // Host command pulse
    input  wire logic             i_instrument_test_query,
    input  wire logic             i_periodic_enable,
    input  wire logic [SW_W-1:0]  i_address_selector_switch, // Section five..one
    input  wire logic             i_cal_written,
    output logic                  o_subtest_start,
    output logic [3:0]            o_subtest_index,
    input  wire logic             i_subtest_done,
    input  wire logic             i_subtest_fail,
    output logic                  o_analog_drive,
    output logic                  o_response_valid,
    output logic [ERR_W-1:0]      o_response_code,
    output logic                  o_queue_push,
    output logic [ERR_W-1:0]      o_queue_code,
    output logic                  o_beep,
    output logic                  o_busy,
    output logic [1:0]            o_baud_sel,
    output logic                  o_baud_valid,
    output logic                  o_bypass,
    output logic                  o_ready
);
    // ==========================================================
    // Switch synchroniser
    // ==========================================================
    logic [SW_W-1:0] sw_meta_reg;
    logic [SW_W-1:0] sw_reg;
    logic            cal_meta_reg;
    logic            cal_reg;
    logic [1:0]      settle_reg;

    // Switch and calibration flag come from outside, two stages each
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sw_meta_reg  <= SW_ALL_OPEN;
            sw_reg       <= SW_ALL_OPEN;
            cal_meta_reg <= 1'b0;
            cal_reg      <= 1'b0;
            settle_reg   <= 2'h0;
        end else begin
            sw_meta_reg  <= i_address_selector_switch;
            sw_reg       <= sw_meta_reg;
            cal_meta_reg <= i_cal_written;
            cal_reg      <= cal_meta_reg;
            settle_reg   <= {settle_reg[0], 1'b1}; // Both stages refilled after reset
        end
    end

    // ==========================================================
    // Baud rate decode
    // ==========================================================
    bitr_baud_type baud_next;
    always_comb begin
        unique case (sw_reg)
            SW_BAUD_9K6:  baud_next = BITR_BAUD_9K6;
            SW_BAUD_19K2: baud_next = BITR_BAUD_19K2;
            SW_BAUD_38K4: baud_next = BITR_BAUD_38K4;
            default:      baud_next = BITR_BAUD_INVALID;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_baud_sel   <= 2'h0;
            o_baud_valid <= 1'b0;
        end else begin
            o_baud_sel   <= baud_next;
            o_baud_valid <= (baud_next != BITR_BAUD_INVALID);
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    typedef enum logic [2:0] {
        BITR_S_SETTLE,
        BITR_S_BYPASS,
        BITR_S_IDLE,
        BITR_S_ISSUE,
        BITR_S_WAIT,
        BITR_S_REPORT,
        BITR_S_HOLD
    } bitr_state_type;

    bitr_state_type state_reg;
    bitr_trig_type  trig_reg;
    logic [ERR_W-1:0] err_reg;
    logic [3:0]       idx_reg;
    logic [3:0]       last_idx;
    logic             pre_fail_reg;
    logic [31:0]      period_reg;
    logic             period_due;
    logic             beep_start;
    logic [2:0]       beep_count;
    logic             beep_busy;
    logic             beep_toggle;
    logic             beep_out;
    logic             fail_now;
    logic [ERR_W-1:0] err_next;
    logic             full_run;

    assign full_run   = (trig_reg == BITR_TRIG_FULL);
    assign last_idx   = full_run ? 4'(ERR_W - 1) : 4'(BASIC_TESTS - 1);
    // Never-calibrated store fails regardless of the subtest answer
    assign fail_now   = i_subtest_fail ||
                        (idx_reg == 4'(BIT_NV_STORE) && !cal_reg);
    assign err_next   = err_reg | (fail_now ? (10'h001 << idx_reg) : ERR_NONE);
    assign period_due = (period_reg == 32'(PERIOD_TICKS - 1));

    // Periodic trigger counter
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            period_reg <= 32'h0000_0000;
        end else if (!i_periodic_enable || period_due) begin
            period_reg <= 32'h0000_0000;
        end else begin
            period_reg <= period_reg + 32'h0000_0001;
        end
    end

    // Main test state machine
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg    <= BITR_S_SETTLE;
            trig_reg     <= BITR_TRIG_POWERUP;
            err_reg      <= ERR_NONE;
            idx_reg      <= 4'h0;
            pre_fail_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                BITR_S_SETTLE: begin
                    if (settle_reg[1] && sw_reg == SW_ALL_OPEN) begin // Reset value of the sync is not the pin
                        state_reg <= BITR_S_BYPASS;
                    end else if (settle_reg[1]) begin
                        trig_reg  <= BITR_TRIG_POWERUP;
                        err_reg   <= ERR_NONE;
                        idx_reg   <= 4'h0;
                        state_reg <= BITR_S_ISSUE;
                    end
                end
                BITR_S_BYPASS: begin
                    if (baud_next == BITR_BAUD_INVALID && sw_reg != SW_ALL_OPEN) begin
                        state_reg <= BITR_S_IDLE;
                    end
                end
                BITR_S_IDLE: begin
                    if (i_instrument_test_query) begin
                        trig_reg <= BITR_TRIG_FULL;
                    end else if (i_confidence_query) begin
                        trig_reg <= BITR_TRIG_CONFIDENCE;
                    end else begin
                        trig_reg <= BITR_TRIG_PERIODIC;
                    end
                    if (i_instrument_test_query || i_confidence_query || period_due) begin
                        err_reg      <= ERR_NONE;
                        idx_reg      <= 4'h0;
                        pre_fail_reg <= 1'b0;
                        state_reg    <= BITR_S_ISSUE;
                    end
                end
                BITR_S_ISSUE: begin
                    state_reg <= BITR_S_WAIT;
                end
                BITR_S_WAIT: begin
                    if (i_subtest_done) begin
                        err_reg <= err_next;
                        if (idx_reg == 4'(BIT_ANALOG_PRE) && fail_now) begin
                            pre_fail_reg <= 1'b1;
                        end
                        if (trig_reg == BITR_TRIG_POWERUP && fail_now) begin
                            state_reg <= BITR_S_HOLD;
                        end else if (idx_reg == last_idx) begin
                            state_reg <= BITR_S_REPORT;
                        end else begin
                            idx_reg   <= idx_reg + 4'h1;
                            state_reg <= BITR_S_ISSUE;
                        end
                    end
                end
                BITR_S_HOLD: begin
                    // Retry the failed power-up subtest once its beeps finish
                    if (!beep_busy && !beep_start) begin
                        err_reg   <= ERR_NONE;
                        state_reg <= BITR_S_ISSUE;
                    end
                end
                BITR_S_REPORT: begin
                    state_reg <= BITR_S_IDLE;
                end
                default: begin
                    state_reg <= BITR_S_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Subtest request and analogue drive
    // ==========================================================
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_subtest_start <= 1'b0;
            o_subtest_index <= 4'h0;
            o_analog_drive  <= 1'b0;
        end else begin
            o_subtest_start <= (state_reg == BITR_S_ISSUE);
            o_subtest_index <= idx_reg;
            // Output stage is driven only by the full test past the loop-back,
            // and only when loop-back passed
            o_analog_drive  <= full_run && (state_reg == BITR_S_ISSUE || state_reg == BITR_S_WAIT) &&
                               idx_reg > 4'(BIT_ANALOG_PRE) && !pre_fail_reg;
        end
    end

    // ==========================================================
    // Response, error queue, status
    // ==========================================================
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_response_valid <= 1'b0;
            o_response_code  <= ERR_PASS;
            o_queue_push     <= 1'b0;
            o_queue_code     <= ERR_NONE;
        end else begin
            o_response_valid <= 1'b0;
            o_queue_push     <= 1'b0;
            if (state_reg == BITR_S_REPORT) begin
                // Zero means pass; any set bit names a failing subtest
                if (trig_reg == BITR_TRIG_CONFIDENCE || trig_reg == BITR_TRIG_FULL) begin
                    o_response_valid <= 1'b1;
                    o_response_code  <= err_reg;
                end
                o_queue_push <= (err_reg != ERR_PASS);
                o_queue_code <= err_reg;
            end else if (state_reg == BITR_S_WAIT && i_subtest_done && fail_now &&
                         trig_reg == BITR_TRIG_POWERUP) begin
                o_queue_push <= 1'b1;
                o_queue_code <= err_next;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy   <= 1'b0;
            o_bypass <= 1'b0;
            o_ready  <= 1'b0;
        end else begin
            o_busy   <= (state_reg != BITR_S_IDLE && state_reg != BITR_S_BYPASS);
            o_bypass <= (state_reg == BITR_S_BYPASS);
            o_ready  <= (state_reg == BITR_S_IDLE);
        end
    end

    // ==========================================================
    // Beep selection
    // ==========================================================
    logic [2:0] fail_beeps;
    logic [ERR_W-1:0] beep_src;

    // Lowest failing bit picks the pattern; analogue stage bits past loop-back are silent
    assign beep_src = (state_reg == BITR_S_REPORT) ? err_reg : err_next;

    always_comb begin
        if (beep_src[BIT_PROG_MEM] || beep_src[BIT_WORK_MEM]) begin
            fail_beeps = BEEPS_MEM;
        end else if (beep_src[BIT_NV_STORE]) begin
            fail_beeps = BEEPS_NV;
        end else if (beep_src[BIT_OPT_BUF]) begin
            fail_beeps = BEEPS_OPT;
        end else if (beep_src[BIT_DIG_POT]) begin
            fail_beeps = BEEPS_POT;
        end else if (beep_src[BIT_LOOPBACK]) begin
            fail_beeps = BEEPS_LOOP;
        end else begin
            fail_beeps = BEEPS_NONE;
        end
    end

    logic ready_beep_done_reg;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ready_beep_done_reg <= 1'b0;
        end else if (beep_start && trig_reg == BITR_TRIG_POWERUP && state_reg == BITR_S_REPORT) begin
            ready_beep_done_reg <= 1'b1;
        end
    end

    always_comb begin
        beep_start = 1'b0;
        beep_count = BEEPS_NONE;
        if (state_reg == BITR_S_WAIT && i_subtest_done && fail_now && trig_reg == BITR_TRIG_POWERUP) begin
            beep_start = 1'b1;
            beep_count = fail_beeps;
        end else if (state_reg == BITR_S_REPORT && err_reg != ERR_PASS) begin
            beep_start = 1'b1;
            beep_count = fail_beeps;
        end else if (state_reg == BITR_S_REPORT && trig_reg == BITR_TRIG_POWERUP && !ready_beep_done_reg) begin
            beep_start = 1'b1;
            beep_count = BEEPS_READY;
        end
    end

    assign beep_toggle = (state_reg == BITR_S_BYPASS);

    bitr_beeper #(
        .HALF_CYCLES (BEEP_HALF)
    ) u_beeper (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_start  (beep_start),
        .i_count  (beep_count),
        .i_toggle (beep_toggle),
        .o_beep   (beep_out),
        .o_busy   (beep_busy)
    );

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_beep <= 1'b0;
        end else begin
            o_beep <= beep_out;
        end
    end
endmodule

// File: bitr_reporter_assertions.sv
// Concurrent checks on the built-in test reporter ports
`timescale 1ns/1ps
module bitr_reporter_chk
    import bitr_pkg::*;
#(
    parameter int BEEP_HALF = 4
) (
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    input wire logic             i_confidence_query,
    input wire logic             i_instrument_test_query,
    input wire logic             o_subtest_start,
    input wire logic [3:0]       o_subtest_index,
    input wire logic             o_analog_drive,
    input wire logic             o_response_valid,
    input wire logic [ERR_W-1:0] o_response_code,
    input wire logic             o_queue_push,
    input wire logic [ERR_W-1:0] o_queue_code,
    input wire logic             o_beep,
    input wire logic             o_bypass,
    input wire logic             o_ready
);
    logic        conf_reg;
    logic        beep_d_reg;
    logic        chg_reg;
    logic [31:0] run_reg;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========================================
    // Helpers: confidence flag, beep level run length
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            conf_reg <= 1'b0;
            beep_d_reg <= 1'b0;
            chg_reg <= 1'b0;
            run_reg <= 32'h0000_0000;
        end else begin
            if (o_ready && i_confidence_query && !i_instrument_test_query)
                conf_reg <= 1'b1;
            else if (o_response_valid)
                conf_reg <= 1'b0;
            beep_d_reg <= o_beep;
            run_reg <= (o_beep != beep_d_reg) ? 32'h0000_0001 : run_reg + 32'h0000_0001;
            // First level inside bypass may be partial, so skip it
            chg_reg <= o_bypass && (chg_reg || (o_beep != beep_d_reg));
        end
    end
    // ==========================================
    // Properties
    property p_push_nonzero;
        o_queue_push |-> o_queue_code != ERR_NONE;
    endproperty
    a_push_nonzero: assert property (p_push_nonzero) else $error("queue push with zero code");
    property p_resp_push;
        o_response_valid && (o_response_code != ERR_PASS) |-> o_queue_push && (o_queue_code == o_response_code);
    endproperty
    a_resp_push: assert property (p_resp_push) else $error("failing response not queued");
    property p_start_idx;
        o_subtest_start |-> o_subtest_index <= 4'h9;
    endproperty
    a_start_idx: assert property (p_start_idx) else $error("subtest index beyond nine");
    property p_conf_idx;
        conf_reg && o_subtest_start |-> o_subtest_index <= 4'h4;
    endproperty
    a_conf_idx: assert property (p_conf_idx) else $error("confidence ran analogue subtest");
    property p_conf_drive;
        conf_reg |-> !o_analog_drive;
    endproperty
    a_conf_drive: assert property (p_conf_drive) else $error("confidence drove output");
    property p_drive_idx;
        o_analog_drive |-> o_subtest_index > 4'h5;
    endproperty
    a_drive_idx: assert property (p_drive_idx) else $error("output driven before loopback");
    property p_query_start;
        o_ready && (i_confidence_query || i_instrument_test_query)
            |-> ##[1:3] (o_subtest_start && o_subtest_index == 4'h0);
    endproperty
    a_query_start: assert property (p_query_start) else $error("query did not start subtest zero");
    property p_bypass_even;
        o_bypass && chg_reg && (o_beep != beep_d_reg) |-> run_reg == BEEP_HALF;
    endproperty
    a_bypass_even: assert property (p_bypass_even) else $error("bypass beep uneven");
    property p_bypass_idle;
        o_bypass |-> !o_ready && !o_response_valid;
    endproperty
    a_bypass_idle: assert property (p_bypass_idle) else $error("bypass while accepting queries");
    c_fail_resp: cover property (o_response_valid && o_response_code != ERR_PASS);
    c_bypass: cover property (o_bypass && o_beep);
    c_drive: cover property (o_analog_drive);
endmodule

bind bitr_reporter bitr_reporter_chk #(.BEEP_HALF(BEEP_HALF)) bitr_reporter_chk_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_confidence_query(i_confidence_query),
    .i_instrument_test_query(i_instrument_test_query), .o_subtest_start(o_subtest_start),
    .o_subtest_index(o_subtest_index), .o_analog_drive(o_analog_drive),
    .o_response_valid(o_response_valid), .o_response_code(o_response_code),
    .o_queue_push(o_queue_push), .o_queue_code(o_queue_code), .o_beep(o_beep),
    .o_bypass(o_bypass), .o_ready(o_ready));

// File: bitr_subtest_model.sv
// Subtest responder standing in for the card's test hardware
`timescale 1ns/1ps
module bitr_subtest_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_start,
    input  wire logic [3:0] i_index,
    input  wire logic [9:0] i_fail_mask,
    input  wire logic [3:0] i_delay,
    output logic            o_done,
    output logic            o_fail
);
    logic [4:0] cnt_reg;
    logic [3:0] idx_reg;
    // ==========================================
    // Answer after i_delay+1 cycles; fail valid only with done
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= 5'h00;
            idx_reg <= 4'h0;
            o_done <= 1'b0;
            o_fail <= 1'b0;
        end else begin
            o_done <= 1'b0;
            o_fail <= ~o_fail; // Toggles so stray samples show
            if (i_start) begin
                cnt_reg <= {1'b0, i_delay} + 5'h01;
                idx_reg <= i_index;
            end else if (cnt_reg == 5'h01) begin
                o_done <= 1'b1;
                o_fail <= i_fail_mask[idx_reg];
                cnt_reg <= 5'h00;
            end else if (cnt_reg != 5'h00) begin
                cnt_reg <= cnt_reg - 5'h01;
            end
        end
    end
endmodule

// File: bitr_reporter_tb.sv
// Self-checking bench for the built-in test reporter
`timescale 1ns/1ps
module bitr_reporter_tb;
    typedef struct packed {
        logic       full;
        logic [9:0] mask;
        logic [9:0] code;
        logic [2:0] beeps;
        logic       drive;
    } bitr_row_type;
    localparam int LIMIT = 30000;
    bitr_row_type rows [10];
    logic clk = 0, rst_n = 0, conf_q = 0, full_q = 0, per_en = 0, cal = 1;
    logic [4:0] sw = 5'h0a;
    logic [9:0] mask = 10'h000, code, qcode;
    logic [3:0] dly = 4'h0, idx;
    logic start, done, fail, drv, rv, push, beep, busy, bvalid, byp, rdy, beep_d = 0;
    logic [1:0] baud;
    int failures = 0, cmp_count = 0, cyc = 0, n_start = 0, n_idx1 = 0, n_drive = 0, n_resp = 0, n_beep = 0;
    int s0, b0, d0, r0, i, k;
    bitr_reporter #(.BEEP_HALF(4), .PERIOD_TICKS(64)) bitr_reporter_i (
        .i_clk(clk), .i_rst_n(rst_n), .i_confidence_query(conf_q), .i_instrument_test_query(full_q),
        .i_periodic_enable(per_en), .i_address_selector_switch(sw), .i_cal_written(cal),
        .o_subtest_start(start), .o_subtest_index(idx), .i_subtest_done(done), .i_subtest_fail(fail),
        .o_analog_drive(drv), .o_response_valid(rv), .o_response_code(code), .o_queue_push(push),
        .o_queue_code(qcode), .o_beep(beep), .o_busy(busy), .o_baud_sel(baud), .o_baud_valid(bvalid),
        .o_bypass(byp), .o_ready(rdy));
    bitr_subtest_model bitr_subtest_model_i (
        .i_clk(clk), .i_rst_n(rst_n), .i_start(start), .i_index(idx), .i_fail_mask(mask),
        .i_delay(dly), .o_done(done), .o_fail(fail));

    // ==========================================
    // Clock, tallies and hang guard
    always #2.5 clk = ~clk;
    always @(negedge clk) begin
        if (start === 1'b1) n_start++;
        if (start === 1'b1 && idx === 4'h1) n_idx1++;
        if (drv === 1'b1) n_drive++;
        if (rv === 1'b1) n_resp++;
        if (beep === 1'b1 && beep_d === 1'b0) n_beep++;
        beep_d = beep;
        cyc++;
        if (cyc == LIMIT) begin
            failures++;
            conclude();
        end
    end

    // ==========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic wait_ready();
        for (k = 0; k < 2000 && rdy !== 1'b1; k++) @(negedge clk);
    endtask
    task automatic do_reset();
        @(posedge clk) rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // One query, its answer, then beeps
    task automatic run(input bitr_row_type r);
        wait_ready();
        s0 = n_start;
        b0 = n_beep;
        d0 = n_drive;
        @(posedge clk);
        mask <= r.mask;
        full_q <= r.full;
        conf_q <= !r.full;
        @(posedge clk);
        full_q <= 1'b0;
        conf_q <= 1'b0;
        for (k = 0; k < 2000 && rv !== 1'b1; k++) @(negedge clk);
        chk("code", r.code, code);
        chk("valid push", {8'h00, 1'b1, r.code != 10'h000}, {8'h00, rv, push});
        chk("starts", r.full ? 10'h00a : 10'h005, 10'(n_start - s0));
        chk("drive", {9'h000, r.drive}, {9'h000, n_drive != d0});
        repeat (150) @(negedge clk);
        chk("beeps", {7'h00, r.beeps}, 10'(n_beep - b0));
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        rows = '{'{0, 10'h000, 10'h000, 3'h0, 0}, '{0, 10'h3ff, 10'h01f, 3'h1, 0},
                 '{0, 10'h010, 10'h010, 3'h6, 0}, '{0, 10'h008, 10'h008, 3'h3, 0},
                 '{0, 10'h3e4, 10'h004, 3'h2, 0}, '{1, 10'h000, 10'h000, 3'h0, 1},
                 '{1, 10'h020, 10'h020, 3'h5, 0}, '{1, 10'h200, 10'h200, 3'h0, 1},
                 '{1, 10'h2a5, 10'h2a5, 3'h1, 0}, '{1, 10'h002, 10'h002, 3'h1, 1}};
        repeat (3) @(negedge clk);
        chk("reset outputs", 10'h000, {4'h0, busy, rdy, rv, push, beep, byp});
        do_reset();
        wait_ready();
        repeat (150) @(negedge clk);
        chk("ready beeps", 10'h003, 10'(n_beep));
        for (i = 0; i < 10; i++) begin
            dly <= 4'(i); // Prompt and slow answers alike
            run(rows[i]);
        end
        // Uncalibrated store fails bit 2 on its own
        @(posedge clk) cal <= 1'b0;
        run('{0, 10'h000, 10'h004, 3'h2, 0});
        @(posedge clk) cal <= 1'b1;
        // Periodic test runs without any response
        wait_ready();
        s0 = n_start;
        r0 = n_resp;
        @(posedge clk) per_en <= 1'b1;
        repeat (200) @(negedge clk);
        @(posedge clk) per_en <= 1'b0;
        chk("periodic run", 10'h001, {9'h000, n_start > s0});
        chk("periodic resp", 10'h000, 10'(n_resp - r0));
        // Baud decode, three codes and one non-code
        for (i = 0; i < 4; i++) begin
            @(posedge clk) sw <= (i == 0) ? 5'h06 : (i == 1) ? 5'h01 : (i == 2) ? 5'h03 : 5'h0a;
            repeat (6) @(negedge clk);
            chk("baud", 10'(i), {8'h00, baud});
            chk("baud valid", {9'h000, i != 3}, {9'h000, bvalid});
        end
        // Bypass: all open, even toggle, leave on valid address
        @(posedge clk) sw <= 5'h1f;
        do_reset();
        repeat (30) @(negedge clk);
        chk("bypass", 10'h001, {9'h000, byp});
        b0 = n_beep;
        repeat (40) @(negedge clk);
        chk("bypass beeping", 10'h001, {9'h000, n_beep - b0 >= 4});
        @(posedge clk) sw <= 5'h0a;
        repeat (50) @(negedge clk);
        chk("bypass left", 10'h000, {9'h000, byp});
        // Power-up failure retries forever
        mask <= 10'h002;
        do_reset();
        s0 = n_idx1;
        repeat (600) @(negedge clk);
        chk("retry", 10'h001, {9'h000, n_idx1 - s0 >= 2});
        chk("held", 10'h000, {9'h000, rdy});
        conclude();
    end
endmodule
